// *** testbench/cwd_watchdog_monitor.sv ***
/* cwd_watchdog_monitor: port assertions for the watchdog.
   assumes it is bound to cwd_watchdog, one clock domain. */
`timescale 1ns/1ps
module cwd_watchdog_monitor (
	input wire logic                  clk,                 // core clock
	input wire logic                  rst_n,               // reset, low
	input wire cwd_pkg::cwd_sfr_req_t sfr_req,             // access
	input wire logic [7:0]            sfr_rdata,           // read data
	input wire logic                  sfr_rvalid,          // read valid
	input wire logic [7:0]            watchdog_control,    // control
	input wire logic                  timeout_status_flag, // status
	input wire logic                  wd_reset_req,        // reset pulse
	input wire logic                  wd_irq               // irq pulse
);
	wire [7:0] c = watchdog_control;
	wire       p = wd_reset_req || wd_irq;
	// unlock state rebuilt from the bus and the control value's unlock bit
	wire       ctrl_wr = (sfr_req.wr && sfr_req.addr == cwd_pkg::CTRL_ADDR) ||
		(sfr_req.bit_wr && sfr_req.addr[7:3] == cwd_pkg::CTRL_BIT_BASE);
	wire       arm_val = sfr_req.wr ? sfr_req.wdata[0] :
		(sfr_req.addr[2:0] == 3'h0 ? sfr_req.bit_val : c[0]);
	wire       any_acc = sfr_req.wr || sfr_req.rd || sfr_req.bit_wr;
	logic      armed_m;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n) armed_m <= 1'b0;
		else if (any_acc) armed_m <= !armed_m && ctrl_wr && arm_val;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (sfr_req.rd && sfr_req.addr == 8'hC0 |=>
		sfr_rvalid && sfr_rdata == $past(c)) else $error("read answer wrong");
	a_no_stray_valid: assert property (!sfr_req.rd |=> !sfr_rvalid)
		else $error("stray read valid");
	a_locked_hold: assert property (!$past(sfr_req.wr || sfr_req.bit_wr) |->
		{c[7:3], c[1:0]} == $past({c[7:3], c[1:0]})) else $error("control changed");
	a_unlock_clear: assert property (c[0] == 1'b0) else $error("unlock bit stored");
	a_quiet_off: assert property (!$past(c[1]) |-> !p) else $error("action while off");
	a_status_set: assert property (p |-> timeout_status_flag) else $error("no status");
	a_irq_select: assert property (wd_irq |-> $past(c[3]) && !$past(c[7]))
		else $error("bad irq");
	a_reset_select: assert property (wd_reset_req |-> !$past(c[3]) || $past(c[7]))
		else $error("bad reset");
	a_pulse_single: assert property (p |=> !p ##1 !wd_irq) else $error("long pulse");
	a_status_sticky: assert property ($fell(timeout_status_flag) |->
		$past(sfr_req.wr || sfr_req.bit_wr)) else $error("status lost");
	a_refuse_locked: assert property (ctrl_wr && !armed_m |=>
		{c[7:3], c[1:0]} == $past({c[7:3], c[1:0]})) else $error("locked write stored");
	a_accept_armed: assert property (sfr_req.wr && sfr_req.addr == cwd_pkg::CTRL_ADDR &&
		armed_m |=> c[7:3] == $past(sfr_req.wdata[7:3]) &&
		c[1:0] == {$past(sfr_req.wdata[1]), 1'b0}) else $error("unlocked write lost");
	c_refused: cover property (ctrl_wr && !armed_m);
	c_irq: cover property (wd_irq);
	c_reset: cover property (wd_reset_req);
	c_read: cover property (sfr_rvalid);
endmodule // cwd_watchdog_monitor
bind cwd_watchdog cwd_watchdog_monitor mon (.clk, .rst_n, .sfr_req, .sfr_rdata, .sfr_rvalid,
	.watchdog_control, .timeout_status_flag, .wd_reset_req, .wd_irq);

// *** testbench/test_cwd_watchdog.sv ***
/* test_cwd_watchdog: self-checking bench for the watchdog.
   assumes cwd_pkg, cwd_watchdog and the monitor are compiled first. */
`timescale 1ns/1ps
module test_cwd_watchdog;
	logic clk = 0, rst_n = 0, xtal = 0, xph = 0, rv, st, rq, irq;
	cwd_pkg::cwd_sfr_req_t req = '0;
	logic [7:0]  rdata, ctrl, d;
	logic [31:0] r = 32'h3DC9;
	logic [3:0]  s;
	int failures = 0, compares = 0, pulses = 0, n, t;
	always #5 clk = ~clk;
	always @(posedge clk) xph <= ~xph;
	always @(posedge clk) if (xph) xtal <= ~xtal; // crystal tick every 4 clk
	always @(posedge clk) if (rq || irq) pulses <= pulses + 1;
	cwd_watchdog dut (.clk(clk), .rst_n(rst_n), .xtal_clk(xtal), .sfr_req(req),
		.sfr_rdata(rdata), .sfr_rvalid(rv), .watchdog_control(ctrl),
		.timeout_status_flag(st), .wd_reset_req(rq), .wd_irq(irq));
	function automatic logic [31:0] lf(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic cwd_pkg::cwd_sfr_req_t f(input int k, input logic [7:0] a, v);
		return '{a, k == 0, k == 1, v, k == 2, v[0]};
	endfunction
	function automatic int tmo(input logic [3:0] sc);
		return sc < 4'h8 ? 512 << sc : 1;
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic acc(input cwd_pkg::cwd_sfr_req_t x);
		req <= x;
		@(posedge clk);
	endtask
	task automatic uw(input logic [7:0] v);
		acc(f(0, 8'hC0, 8'h01));
		acc(f(0, 8'hC0, v));
		acc('0);
	endtask
	task automatic rc(input logic [7:0] e);
		acc(f(1, 8'hC0, 8'h00));
		req <= '0;
		#1 chk("rdata", {8'h01, e}, {7'h00, rv, rdata});
		chk("control", {8'h00, e}, {8'h00, ctrl});
		@(posedge clk);
	endtask
	task automatic final_report;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rc(8'h10);
		acc(f(0, 8'hC1, 8'h01)); // no arm through another address
		acc(f(0, 8'hC0, 8'h32));
		acc(f(1, 8'h80, 8'h00));
		req <= '0;
		#1 chk("other read", 16'h0100, {7'h00, rv, rdata});
		@(posedge clk);
		rc(8'h10);
		acc(f(0, 8'hC0, 8'h32));
		acc(f(0, 8'hC0, 8'h01));
		acc(f(1, 8'hC0, 8'h00));
		acc(f(0, 8'hC0, 8'h32));
		acc('0);
		rc(8'h10);
		repeat (4) begin
			r = lf(r);
			d = r[7:0] & 8'hF8;
			uw(d);
			rc(d);
		end
		acc(f(2, 8'hC0, 8'h01));
		acc(f(2, 8'hC3, 8'h01));
		acc('0);
		rc(d | 8'h08);
		for (int i = 0; i < 5; i++) begin
			s = i == 4 ? 4'h8 : 4'(i);
			uw({s, i[0] || s[3], 3'b010});
			t = 4 * tmo(s);
			#1;
			for (n = 0; n < 20000 && !(rq || irq); n++) begin
				@(posedge clk);
				#1;
			end
			if (n >= 20000) begin
				failures++;
				final_report();
			end
			chk("window", 16'h1, 16'(n >= t - 4 && n <= t + 1));
			chk("irq", 16'(i[0] && s < 4'h8), 16'(irq));
			chk("reset", 16'(!(i[0] && s < 4'h8)), 16'(rq));
			chk("status", 16'h1, 16'(st));
			@(posedge clk);
		end
		repeat (4) begin
			uw(8'h02);
			#1 n = pulses;
			repeat (1200) @(posedge clk);
			chk("refresh", 16'(n), 16'(pulses));
		end
		uw(8'h00);
		#1 n = pulses;
		repeat (2400) @(posedge clk);
		chk("disabled", 16'(n), 16'(pulses));
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc(8'h10);
		final_report();
	end
endmodule // test_cwd_watchdog

// *** verilog/cwd_pkg.sv ***
/*
 * cwd_pkg: constants and carrier types for the crystal clocked watchdog.
 * assumes an 8-bit special-function register bus on the core clock.
 */
package cwd_pkg;

	// control register location and reset value
	localparam logic [7:0] CTRL_ADDR    = 8'hC0;
	localparam logic [4:0] CTRL_BIT_BASE = 5'h18;   // bit addresses C0H..C7H
	localparam logic [7:0] CTRL_RESET   = 8'h10;

	// control register field positions
	localparam int SCALE_MSB   = 7;
	localparam int SCALE_LSB   = 4;
	localparam int IRQ_SEL_BIT = 3;
	localparam int STATUS_BIT  = 2;
	localparam int ENABLE_BIT  = 1;
	localparam int UNLOCK_BIT  = 0;

	// timebase
	localparam int  XTAL_HZ        = 32768;
	localparam int  CNT_BITS       = 16;
	localparam int  BASE_SHIFT     = 9;    // 2^9 crystal periods at scale 0
	localparam int  SCALE_MAX_LIN  = 7;
	localparam real BASE_TIMEOUT_MS = 15.6;

	typedef struct packed {
		logic [7:0] addr;      // byte address
		logic       wr;        // byte write strobe
		logic       rd;        // byte read strobe
		logic [7:0] wdata;     // byte write data
		logic       bit_wr;    // bit write strobe, bit address in addr
		logic       bit_val;   // bit write value
	} cwd_sfr_req_t;

	typedef enum logic [0:0] {
		CWD_LOCKED = 1'b0,
		CWD_ARMED  = 1'b1
	} cwd_unlock_t;

endpackage

// *** verilog/cwd_watchdog.sv ***
/*
 * cwd_watchdog: watchdog supervisor with a crystal-driven 16-bit timebase,
 * locked control register and reset-or-interrupt timeout action.
 * assumes the crystal level arrives as a plain input, slow against clk,
 * and that one register access is presented per strobe cycle.
 * the reset and interrupt pulses leave the block and clear none of its state,
 * so the status flag survives a watchdog reset.
 */
`timescale 1ns/1ps

module cwd_watchdog #(
	parameter int CNT_WIDTH = cwd_pkg::CNT_BITS
) (
	input  wire logic                 clk,            // core clock, 100 MHz
	input  wire logic                 rst_n,          // power-on reset, async, low
	input  wire logic                 xtal_clk,       // 32.768 kHz crystal level
	input  wire cwd_pkg::cwd_sfr_req_t sfr_req,       // register access request
	output logic      [7:0]           sfr_rdata,      // read data, one cycle later
	output logic                      sfr_rvalid,     // read data valid pulse
	output logic      [7:0]           watchdog_control, // control register value
	output logic                      timeout_status_flag, // sticky timeout flag
	output logic                      wd_reset_req,   // system reset request pulse
	output logic                      wd_irq          // watchdog interrupt pulse
);

	// longest linear scale code needs the full counter
	if (CNT_WIDTH < cwd_pkg::BASE_SHIFT + cwd_pkg::SCALE_MAX_LIN) begin : g_width_check
		$error("CNT_WIDTH too small for the longest timeout");
	end

	// terminal count for a scale code
	function automatic logic [CNT_WIDTH-1:0] limit_of(input logic [2:0] code);
		logic [CNT_WIDTH:0] span;
		span = '0;
		span[cwd_pkg::BASE_SHIFT] = 1'b1;
		span = span << code;
		return CNT_WIDTH'(span - 1'b1);
	endfunction

	function automatic logic is_ctrl_bit(input logic [7:0] a);
		return a[7:3] == cwd_pkg::CTRL_BIT_BASE;
	endfunction

	function automatic logic is_ctrl_byte(input logic [7:0] a);
		return a == cwd_pkg::CTRL_ADDR;
	endfunction

	logic [7:0]           ctrl_reg;
	logic [7:0]           ctrl_next;
	logic [CNT_WIDTH-1:0] count_reg;
	logic [1:0]           xtal_sync_reg;
	logic                 xtal_prev_reg;
	logic                 xtal_tick;
	cwd_pkg::cwd_unlock_t unlock_reg;
	logic                 ctrl_access;
	logic                 any_access;
	logic [7:0]           write_data;
	logic                 write_accepted;
	logic                 refresh;
	logic                 enabled;
	logic [3:0]           scale;
	logic                 timeout;
	logic                 reset_reg;
	logic                 irq_reg;
	logic [7:0]           rdata_reg;
	logic                 rvalid_reg;
	logic                 count_clear;
	logic                 action_irq;
	logic                 read_hit;

	assign scale   = ctrl_reg[cwd_pkg::SCALE_MSB:cwd_pkg::SCALE_LSB];
	assign enabled = ctrl_reg[cwd_pkg::ENABLE_BIT];

	// two-flop synchroniser; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xtal_sync_reg <= 2'h0;
		end else begin
			xtal_sync_reg <= {xtal_sync_reg[0], xtal_clk};
		end
	end

	// previous synchronised level; idles low like the pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xtal_prev_reg <= 1'b0;
		end else begin
			xtal_prev_reg <= xtal_sync_reg[1];
		end
	end
	assign xtal_tick = xtal_sync_reg[1] & ~xtal_prev_reg;

	// register access decode
	always_comb begin
		ctrl_access = 1'b0;
		write_data  = ctrl_reg;
		if (sfr_req.wr && is_ctrl_byte(sfr_req.addr)) begin
			ctrl_access = 1'b1;
			write_data  = sfr_req.wdata;
		end else if (sfr_req.bit_wr && is_ctrl_bit(sfr_req.addr)) begin
			ctrl_access = 1'b1;
			write_data[sfr_req.addr[2:0]] = sfr_req.bit_val;
		end
	end
	assign any_access = sfr_req.wr | sfr_req.rd | sfr_req.bit_wr;

	// double-write unlock
	assign write_accepted = ctrl_access && unlock_reg == cwd_pkg::CWD_ARMED;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unlock_reg <= cwd_pkg::CWD_LOCKED;
		end else begin
			case (unlock_reg)
				cwd_pkg::CWD_LOCKED: begin
					if (ctrl_access && write_data[cwd_pkg::UNLOCK_BIT])
						unlock_reg <= cwd_pkg::CWD_ARMED;
				end
				cwd_pkg::CWD_ARMED: begin
					if (any_access)
						unlock_reg <= cwd_pkg::CWD_LOCKED;
				end
				default: unlock_reg <= cwd_pkg::CWD_LOCKED;
			endcase
		end
	end

	assign refresh = write_accepted && write_data[cwd_pkg::ENABLE_BIT];

	// counter restarts when off, on refresh and after each timeout
	assign count_clear = !enabled || refresh || timeout;

	// timeout detection
	always_comb begin
		timeout = 1'b0;
		if (enabled && xtal_tick) begin
			if (scale[3])
				timeout = 1'b1;
			else if (count_reg == limit_of(scale[2:0]))
				timeout = 1'b1;
		end
	end

	// control register; hardware set of the status flag beats a clear
	always_comb begin
		ctrl_next = ctrl_reg;
		if (write_accepted) begin
			ctrl_next = write_data;
			ctrl_next[cwd_pkg::UNLOCK_BIT] = 1'b0;
		end
		if (timeout)
			ctrl_next[cwd_pkg::STATUS_BIT] = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= cwd_pkg::CTRL_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// timebase counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else if (count_clear) begin
			count_reg <= '0;
		end else if (xtal_tick) begin
			count_reg <= count_reg + 1'b1;
		end
	end

	// scale codes 8 and above always reset, whatever the select bit
	assign action_irq = !scale[3] && ctrl_reg[cwd_pkg::IRQ_SEL_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_reg <= 1'b0;
		end else begin
			reset_reg <= timeout && !action_irq;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= timeout && action_irq;
		end
	end

	// read port; every read strobe is answered, whatever its address
	assign read_hit = sfr_req.rd && is_ctrl_byte(sfr_req.addr);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= sfr_req.rd;
		end
	end

	// unmapped addresses read as zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
		end else if (read_hit) begin
			rdata_reg <= ctrl_reg;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign sfr_rdata           = rdata_reg;
	assign sfr_rvalid          = rvalid_reg;
	assign watchdog_control    = ctrl_reg;
	assign timeout_status_flag = ctrl_reg[cwd_pkg::STATUS_BIT];
	assign wd_reset_req        = reset_reg;
	assign wd_irq              = irq_reg;

endmodule // cwd_watchdog
